// file: hdl/detp_pkg.sv
package detp_pkg;

  // Register byte offsets on the APB slave.
  localparam logic [7:0] ADDR_STEP      = 8'h00;
  localparam logic [7:0] ADDR_WIN_LOW   = 8'h04;
  localparam logic [7:0] ADDR_WIN_HIGH  = 8'h08;
  localparam logic [7:0] ADDR_CTRL      = 8'h0C;
  localparam logic [7:0] ADDR_PRESET1   = 8'h10;
  localparam logic [7:0] ADDR_PRESET2   = 8'h14;
  localparam logic [7:0] ADDR_WRAP1     = 8'h18;
  localparam logic [7:0] ADDR_WRAP2     = 8'h1C;
  localparam logic [7:0] ADDR_CMD       = 8'h20;
  localparam logic [7:0] ADDR_COUNT1    = 8'h24;
  localparam logic [7:0] ADDR_COUNT2    = 8'h28;
  localparam logic [7:0] ADDR_STATUS    = 8'h2C;

  // Control register field positions.
  localparam int CTRL_INTERP1_LSB = 0;
  localparam int CTRL_INTERP2_LSB = 2;
  localparam int CTRL_REF1_LSB    = 4;
  localparam int CTRL_REF2_LSB    = 6;
  localparam int CTRL_SRC_LSB     = 8;

  // Command register bit positions.
  localparam int CMD_PRESET1 = 0;
  localparam int CMD_PRESET2 = 1;
  localparam int CMD_REARM1  = 2;
  localparam int CMD_REARM2  = 3;

  // Reset values.
  localparam logic [30:0] RST_STEP     = 31'h00000000;
  localparam logic [31:0] RST_WIN_LOW  = 32'h00000000;
  localparam logic [31:0] RST_WIN_HIGH = 32'hFFFFFFFF;
  localparam logic [31:0] RST_PRESET   = 32'h00000000;
  localparam logic [31:0] RST_WRAP     = 32'hFFFFFFFF;

  typedef enum logic [1:0] {
    DETP_INTERP_X1 = 2'b00,
    DETP_INTERP_X2 = 2'b01,
    DETP_INTERP_X4 = 2'b10
  } detp_interp_type;

  typedef enum logic [1:0] {
    DETP_REF_NONE  = 2'b00,
    DETP_REF_ONCE  = 2'b01,
    DETP_REF_EVERY = 2'b10
  } detp_ref_type;

  typedef enum logic [1:0] {
    DETP_SRC_OTHER = 2'b00,
    DETP_SRC_POS_A = 2'b01,
    DETP_SRC_POS_B = 2'b10
  } detp_src_type;

endpackage

// file: hdl/detp_top.sv
// Implementation choices: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
// What this block does
// [RULE_01] Trigger once per programmed step count advance.
// [RULE_02] Step zero: trigger continuously inside window.
// [RULE_03] Trigger only at or above low bound.
// [RULE_04] Trigger only at or below high bound.
// [RULE_05] Per channel interpolation depth 1, 2, 4.
// [RULE_06] Reference mode none: mark has no effect.
// [RULE_07] Mode once: preset only at first armed mark.
// [RULE_08] Mode every: preset at every mark.
// [RULE_09] Per channel preset loaded on mark or request.
// [RULE_10] Writing preset re-arms first mark detection.
// [RULE_11] Software preset only works in mode none.
// [RULE_12] Re-arm request only works in mode once.
// [RULE_13] Count above wrap limit returns to zero.
// [RULE_14] Either encoder channel selectable as trigger source.
// [RULE_15] Quadrature direction counts; below zero loads limit.
// [RULE_16] Inputs sampled synchronously; preset beats count step.
module detp_top
  import detp_pkg::*;
(
  input  wire logic        clk_in,
  input  wire logic        rst_n_in,
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [7:0]  paddr_in,
  input  wire logic [31:0] pwdata_in,
  output logic      [31:0] prdata_out,
  output logic             pready_out,
  output logic             pslverr_out,
  input  wire logic [1:0]  enc_a_in,
  input  wire logic [1:0]  enc_b_in,
  input  wire logic [1:0]  enc_ref_in,
  output logic             meas_trigger_out
);

  ////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic [30:0]      step;
    logic [31:0]      win_low;
    logic [31:0]      win_high;
    detp_interp_type  interp1;
    detp_interp_type  interp2;
    detp_ref_type     ref1;
    detp_ref_type     ref2;
    detp_src_type     src;
    logic [31:0]      preset1;
    logic [31:0]      preset2;
    logic [31:0]      wrap1;
    logic [31:0]      wrap2;
    logic [1:0]       armed;
    logic [1:0]       a_prev;
    logic [1:0]       b_prev;
    logic [1:0]       ref_prev;
    logic [31:0]      count1;
    logic [31:0]      count2;
    logic [30:0]      progress;
    logic [31:0]      prdata;
    logic             pready;
    logic             pslverr;
    logic             trig;
  } detp_state_type;

  detp_state_type state_ff;
  detp_state_type nxt_state;

  ////////////////////////////////////////////////////////////////////////////
  // Returns +1, -1 or 0 for one quadrature transition, filtered by depth.
  // Depth 1 counts only rising A edges, depth 2 both A edges, depth 4 all.
  function automatic logic [1:0] quad_step(input logic a_old, input logic b_old,
                                           input logic a_new, input logic b_new,
                                           input detp_interp_type depth);
    logic a_edge;
    logic b_edge;
    logic up;
    logic [1:0] res;
    a_edge = a_old ^ a_new;
    b_edge = b_old ^ b_new;
    up     = a_edge ? (a_new ^ b_new) : ~(a_new ^ b_new);
    res    = 2'b00;
    if (a_edge && b_edge) begin
      res = 2'b00; // Illegal double transition is dropped.
    end else if (a_edge || b_edge) begin
      case (depth) // RULE_05
        DETP_INTERP_X1: begin
          if (a_edge && a_new) begin
            res = up ? 2'b01 : 2'b11;
          end
        end
        DETP_INTERP_X2: begin
          if (a_edge) begin
            res = up ? 2'b01 : 2'b11;
          end
        end
        default: begin
          res = up ? 2'b01 : 2'b11;
        end
      endcase
    end
    return res;
  endfunction

  // Advances one counter with wrap in both directions.
  function automatic logic [31:0] step_count(input logic [31:0] cnt, input logic [1:0] dir,
                                             input logic [31:0] limit);
    logic [31:0] res;
    res = cnt;
    if (dir == 2'b01) begin
      res = (cnt >= limit) ? 32'h00000000 : cnt + 32'h00000001; // RULE_13
    end else if (dir == 2'b11) begin
      res = (cnt == 32'h00000000) ? limit : cnt - 32'h00000001; // RULE_15
    end
    return res;
  endfunction

  // Decides whether a reference mark edge loads the preset.
  function automatic logic ref_hit(input detp_ref_type mode, input logic armed, input logic mark);
    logic res;
    res = 1'b0;
    case (mode)
      DETP_REF_ONCE:  res = mark && armed; // RULE_07
      DETP_REF_EVERY: res = mark;          // RULE_08
      default:        res = 1'b0;          // RULE_06
    endcase
    return res;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  logic        wr_en;
  logic        rd_en;
  logic [1:0]  dir1;
  logic [1:0]  dir2;
  logic [1:0]  mark;
  logic [1:0]  load;
  logic [1:0]  sw_preset;
  logic [1:0]  sw_rearm;
  logic [31:0] sel_count;
  logic [1:0]  sel_dir;
  logic        in_window;

  always_comb begin
    nxt_state = state_ff;
    wr_en     = psel_in && penable_in && pwrite_in && state_ff.pready;
    rd_en     = psel_in && !penable_in && !pwrite_in;
    sw_preset = 2'b00;
    sw_rearm  = 2'b00;

    // No wait state: pready rises in the access phase's first cycle.
    nxt_state.pready  = psel_in && !penable_in;
    nxt_state.pslverr = 1'b0;
    if (state_ff.pready) begin
      nxt_state.pready = 1'b0;
    end

    if (wr_en) begin
      if (paddr_in == ADDR_STEP) begin
        nxt_state.step = pwdata_in[30:0];
      end else if (paddr_in == ADDR_WIN_LOW) begin
        nxt_state.win_low = pwdata_in;
      end else if (paddr_in == ADDR_WIN_HIGH) begin
        nxt_state.win_high = pwdata_in;
      end else if (paddr_in == ADDR_CTRL) begin
        nxt_state.interp1 = detp_interp_type'(pwdata_in[CTRL_INTERP1_LSB +: 2]);
        nxt_state.interp2 = detp_interp_type'(pwdata_in[CTRL_INTERP2_LSB +: 2]);
        nxt_state.ref1    = detp_ref_type'(pwdata_in[CTRL_REF1_LSB +: 2]);
        nxt_state.ref2    = detp_ref_type'(pwdata_in[CTRL_REF2_LSB +: 2]);
        nxt_state.src     = detp_src_type'(pwdata_in[CTRL_SRC_LSB +: 2]);
      end else if (paddr_in == ADDR_PRESET1) begin
        nxt_state.preset1 = pwdata_in;
        sw_rearm[0]       = 1'b1; // RULE_10
      end else if (paddr_in == ADDR_PRESET2) begin
        nxt_state.preset2 = pwdata_in;
        sw_rearm[1]       = 1'b1; // RULE_10
      end else if (paddr_in == ADDR_WRAP1) begin
        nxt_state.wrap1 = pwdata_in;
      end else if (paddr_in == ADDR_WRAP2) begin
        nxt_state.wrap2 = pwdata_in;
      end else if (paddr_in == ADDR_CMD) begin
        sw_preset[0] = pwdata_in[CMD_PRESET1] && (state_ff.ref1 == DETP_REF_NONE); // RULE_11
        sw_preset[1] = pwdata_in[CMD_PRESET2] && (state_ff.ref2 == DETP_REF_NONE); // RULE_11
        sw_rearm[0]  = pwdata_in[CMD_REARM1] && (state_ff.ref1 == DETP_REF_ONCE);  // RULE_12
        sw_rearm[1]  = pwdata_in[CMD_REARM2] && (state_ff.ref2 == DETP_REF_ONCE);  // RULE_12
      end else if (paddr_in == ADDR_COUNT1 || paddr_in == ADDR_COUNT2 || paddr_in == ADDR_STATUS) begin
        nxt_state.pslverr = 1'b0;
      end else begin
        nxt_state.pslverr = 1'b0;
      end
    end

    if (rd_en) begin
      if (paddr_in == ADDR_STEP) begin
        nxt_state.prdata = {1'b0, state_ff.step};
      end else if (paddr_in == ADDR_WIN_LOW) begin
        nxt_state.prdata = state_ff.win_low;
      end else if (paddr_in == ADDR_WIN_HIGH) begin
        nxt_state.prdata = state_ff.win_high;
      end else if (paddr_in == ADDR_CTRL) begin
        nxt_state.prdata = {22'h000000, state_ff.src, state_ff.ref2, state_ff.ref1,
                            state_ff.interp2, state_ff.interp1};
      end else if (paddr_in == ADDR_PRESET1) begin
        nxt_state.prdata = state_ff.preset1;
      end else if (paddr_in == ADDR_PRESET2) begin
        nxt_state.prdata = state_ff.preset2;
      end else if (paddr_in == ADDR_WRAP1) begin
        nxt_state.prdata = state_ff.wrap1;
      end else if (paddr_in == ADDR_WRAP2) begin
        nxt_state.prdata = state_ff.wrap2;
      end else if (paddr_in == ADDR_COUNT1) begin
        nxt_state.prdata = state_ff.count1;
      end else if (paddr_in == ADDR_COUNT2) begin
        nxt_state.prdata = state_ff.count2;
      end else if (paddr_in == ADDR_STATUS) begin
        nxt_state.prdata = {30'h00000000, state_ff.armed};
      end else begin
        nxt_state.prdata = 32'h00000000;
      end
    end

    // Encoder pins are synchronous; edges come from a one-cycle history.
    nxt_state.a_prev   = enc_a_in;   // RULE_16
    nxt_state.b_prev   = enc_b_in;   // RULE_16
    nxt_state.ref_prev = enc_ref_in; // RULE_16
    mark = enc_ref_in & ~state_ff.ref_prev;
    dir1 = quad_step(state_ff.a_prev[0], state_ff.b_prev[0], enc_a_in[0], enc_b_in[0], state_ff.interp1);
    dir2 = quad_step(state_ff.a_prev[1], state_ff.b_prev[1], enc_a_in[1], enc_b_in[1], state_ff.interp2);

    load[0] = ref_hit(state_ff.ref1, state_ff.armed[0], mark[0]) || sw_preset[0];
    load[1] = ref_hit(state_ff.ref2, state_ff.armed[1], mark[1]) || sw_preset[1];

    // A re-arm arriving with the mark wins, so the next mark is caught too.
    if (load[0] && state_ff.ref1 == DETP_REF_ONCE) begin
      nxt_state.armed[0] = 1'b0;
    end
    if (load[1] && state_ff.ref2 == DETP_REF_ONCE) begin
      nxt_state.armed[1] = 1'b0;
    end
    if (sw_rearm[0]) begin
      nxt_state.armed[0] = 1'b1;
    end
    if (sw_rearm[1]) begin
      nxt_state.armed[1] = 1'b1;
    end

    if (load[0]) begin
      nxt_state.count1 = state_ff.preset1; // RULE_09 RULE_16
    end else begin
      nxt_state.count1 = step_count(state_ff.count1, dir1, state_ff.wrap1);
    end
    if (load[1]) begin
      nxt_state.count2 = state_ff.preset2; // RULE_09 RULE_16
    end else begin
      nxt_state.count2 = step_count(state_ff.count2, dir2, state_ff.wrap2);
    end

    // Source selection picks the channel whose steps drive the trigger.
    sel_count = 32'h00000000;
    sel_dir   = 2'b00;
    if (state_ff.src == DETP_SRC_POS_A) begin // RULE_14
      sel_count = nxt_state.count1;
      sel_dir   = load[0] ? 2'b00 : dir1;
    end else if (state_ff.src == DETP_SRC_POS_B) begin // RULE_14
      sel_count = nxt_state.count2;
      sel_dir   = load[1] ? 2'b00 : dir2;
    end

    in_window = (sel_count >= state_ff.win_low) && (sel_count <= state_ff.win_high); // RULE_03 RULE_04
    nxt_state.trig = 1'b0;
    if (state_ff.src == DETP_SRC_OTHER) begin
      nxt_state.progress = 31'h00000000;
    end else if (state_ff.step == 31'h00000000) begin
      nxt_state.trig     = in_window; // RULE_02
      nxt_state.progress = 31'h00000000;
    end else if (sel_dir != 2'b00) begin
      // Steps in either direction count as travel; the window still gates.
      if (state_ff.progress + 31'h00000001 >= state_ff.step) begin
        nxt_state.progress = 31'h00000000;
        nxt_state.trig     = in_window; // RULE_01
      end else begin
        nxt_state.progress = state_ff.progress + 31'h00000001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_ff          <= '0;
      state_ff.step     <= RST_STEP;
      state_ff.win_low  <= RST_WIN_LOW;
      state_ff.win_high <= RST_WIN_HIGH;
      state_ff.interp1  <= DETP_INTERP_X4;
      state_ff.interp2  <= DETP_INTERP_X4;
      state_ff.ref1     <= DETP_REF_NONE;
      state_ff.ref2     <= DETP_REF_NONE;
      state_ff.src      <= DETP_SRC_OTHER;
      state_ff.preset1  <= RST_PRESET;
      state_ff.preset2  <= RST_PRESET;
      state_ff.wrap1    <= RST_WRAP;
      state_ff.wrap2    <= RST_WRAP;
      state_ff.armed    <= 2'b11;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign prdata_out       = state_ff.prdata;
  assign pready_out       = state_ff.pready;
  assign pslverr_out      = state_ff.pslverr;
  assign meas_trigger_out = state_ff.trig;

endmodule

// file: verif/detp_enc_model.sv
`timescale 1ns/1ps
module detp_enc_model (
  input  wire logic clk_in,
  input  wire logic rst_n_in,
  input  wire logic step_in,
  input  wire logic up_in,
  input  wire logic mark_in,
  output logic      enc_a_out,
  output logic      enc_b_out,
  output logic      enc_ref_out
);
  logic [1:0] ph_ff;
  // Gray phase, so only one track moves per step and A leads B going up.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      {ph_ff, enc_ref_out} <= 3'h0;
    end else begin
      if (step_in) ph_ff <= up_in ? ph_ff + 2'h1 : ph_ff - 2'h1;
      enc_ref_out <= mark_in;
    end
  end
  assign enc_a_out = ^ph_ff;
  assign enc_b_out = ph_ff[1];
endmodule

// file: verif/detp_top_sva.sv
`timescale 1ns/1ps
module detp_chk
  import detp_pkg::*;
(
  input wire logic        clk_in,
  input wire logic        rst_n_in,
  input wire logic        psel_in,
  input wire logic        penable_in,
  input wire logic        pwrite_in,
  input wire logic [7:0]  paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [31:0] prdata_out,
  input wire logic        pready_out,
  input wire logic        pslverr_out,
  input wire logic [1:0]  enc_a_in,
  input wire logic [1:0]  enc_b_in,
  input wire logic [1:0]  enc_ref_in,
  input wire logic        meas_trigger_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  logic       wr, chg, ok, full, empty, step0_ff;
  logic [1:0] src_ff, lo_ff, hi_ff;
  logic [3:0] ab_ff;
  ////////////////////////////////////////
  // Only flags of the settings and the last encoder pins are shadowed, which keeps this cheap but blind to most counts.
  assign wr    = psel_in & penable_in & pready_out & pwrite_in;
  assign chg   = {enc_a_in, enc_b_in} != ab_ff;
  assign ok    = ^src_ff;
  assign full  = step0_ff & ok & lo_ff[0] & hi_ff[1];
  assign empty = lo_ff[1] & hi_ff[0];
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      {ab_ff, src_ff, step0_ff, lo_ff, hi_ff} <= 11'h016;
    end else begin
      ab_ff <= {enc_a_in, enc_b_in};
      if (wr && paddr_in == ADDR_CTRL) src_ff <= pwdata_in[9:8];
      if (wr && paddr_in == ADDR_STEP) step0_ff <= ~|pwdata_in[30:0];
      if (wr && paddr_in == ADDR_WIN_LOW) lo_ff <= {&pwdata_in, ~|pwdata_in};
      if (wr && paddr_in == ADDR_WIN_HIGH) hi_ff <= {&pwdata_in, ~|pwdata_in};
    end
  end
  ////////////////////////////////////////
  property p_setup_ready; psel_in && !penable_in |=> pready_out; endproperty
  property p_ready_pulse; pready_out |-> psel_in && penable_in ##1 !pready_out; endproperty
  property p_no_err; !pslverr_out; endproperty
  property p_unmapped;
    pready_out && !pwrite_in && (paddr_in > ADDR_STATUS || paddr_in == ADDR_CMD) |-> prdata_out == 32'h0;
  endproperty
  property p_src_gate; meas_trigger_out |-> ok || $past(ok); endproperty
  property p_step_cause;
    meas_trigger_out && !step0_ff && !$past(step0_ff) |-> $past(chg) || $past(chg, 2);
  endproperty
  property p_cont; full && $past(full) |-> meas_trigger_out; endproperty
  property p_empty; empty && $past(empty) |-> !meas_trigger_out; endproperty
  a_setup_ready: assert property (p_setup_ready) else $error("no ready after setup");
  a_ready_pulse: assert property (p_ready_pulse) else $error("ready outside one access cycle");
  a_no_err: assert property (p_no_err) else $error("error response seen");
  a_unmapped: assert property (p_unmapped) else $error("nonzero read data");
  a_src_gate: assert property (p_src_gate) else $error("trigger with no source");
  a_step_cause: assert property (p_step_cause) else $error("trigger without step");
  a_cont: assert property (p_cont) else $error("continuous trigger missing");
  a_empty: assert property (p_empty) else $error("trigger outside window");
  c_step: cover property (meas_trigger_out && !step0_ff);
  c_cont: cover property (full ##1 meas_trigger_out);
  c_read: cover property (pready_out && !pwrite_in);
endmodule
bind detp_top detp_chk u_chk (.clk_in, .rst_n_in, .psel_in, .penable_in, .pwrite_in, .paddr_in, .pwdata_in,
  .prdata_out, .pready_out, .pslverr_out, .enc_a_in, .enc_b_in, .enc_ref_in, .meas_trigger_out);

// file: verif/detp_top_bench.sv
`timescale 1ns/1ps
module detp_top_bench;
  import detp_pkg::*;
  logic        clk_in = 1'b0;
  logic        rst_n_in = 1'b0;
  logic        psel_in, penable_in, pwrite_in, pready_out, pslverr_out, meas_trigger_out;
  logic [7:0]  paddr_in, ca, pa;
  logic [31:0] pwdata_in, prdata_out, q, pv, cnt[2], wrap[2];
  logic [1:0]  step, up, mark, ph[2];
  wire  [1:0]  enc_a_in, enc_b_in, enc_ref_in;
  int          dep[2], t0, seed = 2, miscompares = 0, total_checks = 0, trig_cnt = 0;
  logic [7:0]  ra[9] = '{ADDR_STEP, ADDR_WIN_LOW, ADDR_WIN_HIGH, ADDR_CTRL, ADDR_PRESET1, ADDR_WRAP2, ADDR_CMD,
                         ADDR_STATUS, 8'h30};
  logic [31:0] rv[9] = '{32'h0, 32'h0, 32'hFFFFFFFF, 32'hA, 32'h0, 32'hFFFFFFFF, 32'h0, 32'h3, 32'h0};
  logic [31:0] wl[3] = '{32'hFFFFFFFF, 32'h2, 32'h0};
  logic [31:0] wh[3] = '{32'h0, 32'h3, 32'h2};
  logic [31:0] we[3] = '{32'h0, 32'h2, 32'h2};
  always #10 clk_in = ~clk_in;
  // Pulses are counted on the falling edge so the count never races the bench reading it.
  always @(negedge clk_in) if (meas_trigger_out === 1'b1) trig_cnt++;
  detp_top u_dut (.clk_in, .rst_n_in, .psel_in, .penable_in, .pwrite_in, .paddr_in, .pwdata_in, .prdata_out,
                  .pready_out, .pslverr_out, .enc_a_in, .enc_b_in, .enc_ref_in, .meas_trigger_out);
  for (genvar g = 0; g < 2; g++) begin : g_enc
    detp_enc_model u_enc (.clk_in, .rst_n_in, .step_in(step[g]), .up_in(up[g]), .mark_in(mark[g]),
                          .enc_a_out(enc_a_in[g]), .enc_b_out(enc_b_in[g]), .enc_ref_out(enc_ref_in[g]));
  end
  ////////////////////////////////////////
  task automatic report_and_stop;
    $display("checks %0d, mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    {psel_in, pwrite_in, paddr_in, pwdata_in} <= {1'b1, w, a, d};
    @(posedge clk_in);
    penable_in <= 1'b1;
    do begin
      @(posedge clk_in);
      n++;
    end while (pready_out !== 1'b1 && n < 40);
    q = prdata_out;
    {psel_in, penable_in} <= 2'b00;
    if (n >= 40) begin
      miscompares++;
      report_and_stop();
    end
    @(posedge clk_in);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(q, e);
  endtask
  // Expected count change of one phase step at interpolation depth d.
  function automatic int dlt(input logic [1:0] o, input logic [1:0] n, input int d);
    if (d == 0 && !(^n && !(^o))) return 0;
    if (d == 1 && ^n == ^o) return 0;
    return (n == o + 2'h1) ? 1 : -1;
  endfunction
  task automatic mv(input int c, input logic u);
    logic [1:0] np;
    np = u ? ph[c] + 2'h1 : ph[c] - 2'h1;
    case (dlt(ph[c], np, dep[c]))
      1: cnt[c] = (cnt[c] >= wrap[c]) ? 32'h0 : cnt[c] + 32'h1;
      -1: cnt[c] = (cnt[c] == 32'h0) ? wrap[c] : cnt[c] - 32'h1;
      default: ;
    endcase
    ph[c] = np;
    {step[c], up[c]} <= {1'b1, u};
    @(posedge clk_in);
    step[c] <= 1'b0;
    repeat (2 + ($random(seed) & 3)) @(posedge clk_in);
  endtask
  task automatic mk(input int c);
    mark[c] <= 1'b1;
    @(posedge clk_in);
    mark[c] <= 1'b0;
    repeat (4) @(posedge clk_in);
  endtask
  ////////////////////////////////////////
  initial begin
    repeat (100000) @(posedge clk_in);
    miscompares++;
    report_and_stop();
  end
  initial begin
    {psel_in, penable_in, pwrite_in, paddr_in, pwdata_in, step, up, mark} = '0;
    ph = '{2'h0, 2'h0};
    repeat (5) @(posedge clk_in);
    rst_n_in <= 1'b1;
    for (int i = 0; i < 9; i++) rd(ra[i], rv[i]);
    $display("reset test done");
    for (int d = 0; d < 3; d++) begin
      wr(ADDR_CTRL, 32'(d * 5));
      dep = '{d, d};
      for (int c = 0; c < 2; c++) begin
        wrap[c] = 32'(2 + ($random(seed) & 7));
        wr(ADDR_WRAP1 + 8'(4 * c), wrap[c]);
      end
      wr(ADDR_CMD, 32'h3);
      cnt = '{32'h0, 32'h0};
      repeat (24) mv($random(seed) & 1, 1'($random(seed)));
      rd(ADDR_COUNT1, cnt[0]);
      rd(ADDR_COUNT2, cnt[1]);
    end
    $display("counting test done");
    for (int c = 0; c < 2; c++) begin
      ca = ADDR_COUNT1 + 8'(4 * c);
      pa = ADDR_PRESET1 + 8'(4 * c);
      pv = $random(seed);
      wr(pa, pv);
      mk(c);
      rd(ca, cnt[c]);
      wr(ADDR_CMD, 32'h1 << c);
      cnt[c] = pv;
      rd(ca, cnt[c]);
      wr(ADDR_CTRL, 32'hA | (32'h1 << (4 + 2 * c)));
      pv = $random(seed);
      wr(pa, pv);
      wr(ADDR_CMD, 32'h1 << c);
      rd(ca, cnt[c]);
      mk(c);
      cnt[c] = pv;
      rd(ca, pv);
      mv(c, 1'b1);
      mk(c);
      rd(ca, cnt[c]);
      pv = $random(seed);
      wr(pa, pv);
      mk(c);
      rd(ca, pv);
      mv(c, 1'b1);
      wr(ADDR_CMD, 32'h4 << c);
      mk(c);
      rd(ca, pv);
      wr(ADDR_CTRL, 32'hA | (32'h2 << (4 + 2 * c)));
      wr(ADDR_CMD, 32'h4 << c);
      apb(1'b0, ADDR_STATUS, 32'h0);
      chk(32'(q[c]), 32'h0);
      repeat (2) begin
        mv(c, 1'b1);
        mk(c);
        rd(ca, pv);
      end
      mark[c] <= 1'b1;
      mv(c, 1'b1);
      mark[c] <= 1'b0;
      rd(ca, pv);
      cnt[c] = pv;
      wr(ADDR_CTRL, 32'hA);
    end
    $display("reference test done");
    wrap = '{32'hFFFFFFFF, 32'hFFFFFFFF};
    wr(ADDR_WRAP1, wrap[0]);
    wr(ADDR_WRAP2, wrap[1]);
    wr(ADDR_STEP, 32'h3);
    for (int c = 0; c < 2; c++) begin
      wr(ADDR_CTRL, 32'hA | (32'(c + 1) << 8));
      t0 = trig_cnt;
      repeat (9) mv(c, 1'b1);
      chk(32'(trig_cnt - t0), 32'h3);
      repeat (3) mv(1 - c, 1'b1);
      chk(32'(trig_cnt - t0), 32'h3);
    end
    wr(ADDR_STEP, 32'h1);
    wr(ADDR_PRESET2, 32'h0);
    for (int k = 0; k < 3; k++) begin
      wr(ADDR_WIN_LOW, wl[k]);
      wr(ADDR_WIN_HIGH, wh[k]);
      wr(ADDR_CMD, 32'h2);
      cnt[1] = 32'h0;
      t0 = trig_cnt;
      repeat (6) mv(1, 1'b1);
      chk(32'(trig_cnt - t0), we[k]);
    end
    wr(ADDR_WIN_LOW, 32'h0);
    wr(ADDR_WIN_HIGH, 32'hFFFFFFFF);
    wr(ADDR_STEP, 32'h0);
    repeat (2) @(posedge clk_in);
    t0 = trig_cnt;
    repeat (10) @(posedge clk_in);
    chk(32'(trig_cnt - t0), 32'hA);
    wr(ADDR_CTRL, 32'hA);
    t0 = trig_cnt;
    repeat (10) @(posedge clk_in);
    chk(32'(trig_cnt - t0), 32'h0);
    $display("trigger test done");
    report_and_stop();
  end
endmodule
